/* File: cpm_pkg.sv */
// Constants and types for the CPU power-mode controller.
// Assumes an 8-bit special-register port with address, write and read strobes.
package cpm_pkg;
  localparam logic [7:0]  CPM_POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0]  CPM_POWER_CONTROL_RST  = 8'h00;
  localparam int          CPM_IDLE_BIT           = 0;
  localparam int          CPM_STOP_BIT           = 1;
  localparam int          CPM_FLAGS_LSB          = 2;
  localparam logic [15:0] CPM_RESET_VECTOR       = 16'h0000;
  localparam int          CPM_MCD_TIMEOUT_US     = 100;
  localparam int          CPM_CLK_MHZ            = 125;
  localparam int          CPM_MCD_CYCLES         = CPM_MCD_TIMEOUT_US * CPM_CLK_MHZ;

  typedef enum logic [1:0] {
    CPM_RUN   = 2'b00,
    CPM_IDLE  = 2'b01,
    CPM_STOP  = 2'b10,
    CPM_RESET = 2'b11
  } cpm_mode_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpm_sfr_t;

  typedef struct packed {
    logic cpuHalt;
    logic oscStop;
    logic periphStop;
    logic intGate;
  } cpm_gate_t;
endpackage

/* File: cpm_sync.sv */
// Three-stage synchroniser with agreement of the last two stages.
// Assumes an asynchronous level input.
module cpm_sync
  import cpm_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

/* File: cpm_power_mode_control.sv */
// Power-mode controller: idle, stop, oscillator suspend and reset-driven wake.
// Assumes the core pulses instrDone at each instruction boundary and that
// the core restarts at resetVector whenever coreReset is high.
module cpm_power_mode_control
  import cpm_pkg::*;
#(
  parameter int MCD_CYCLES = CPM_MCD_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire cpm_sfr_t    sfr,
  input  wire logic        instrDone,
  input  wire logic        intPending,
  input  wire logic        wdtEnable,
  input  wire logic        wdtExpire,
  input  wire logic        mcdEnable,
  input  wire logic        extResetPin,
  input  wire logic        suspendReq,
  input  wire logic        usbEvent,
  input  wire logic        vbusPin,
  input  wire logic        vbus_wake_polarity,
  output logic [7:0]       rdata,
  output cpm_gate_t        gate,
  output logic             coreReset,
  output logic [15:0]      resetVector,
  output logic             serviceInt,
  output logic             intOscRun,
  output logic [1:0]       mode
);
  localparam int               MCD_W    = $clog2(MCD_CYCLES + 1);
  localparam logic [MCD_W-1:0] MCD_LAST = MCD_W'(MCD_CYCLES - 1);
  localparam logic [MCD_W-1:0] MCD_FULL = MCD_W'(MCD_CYCLES);
  localparam logic [MCD_W-1:0] MCD_STEP = MCD_W'(1);

  // Below two the detector would fire on the first stop cycle
  if (MCD_CYCLES < 2) begin : gBadMcd
    $error("MCD_CYCLES must be at least 2");
  end

  // Both strobes decode the same address
  function automatic logic hitsPowerControl(input logic strobe, input logic [7:0] addr);
    return strobe && (addr == CPM_POWER_CONTROL_ADDR);
  endfunction

  cpm_mode_t        state;
  cpm_mode_t        next_state;
  logic [5:0]       general_flags;
  logic [5:0]       next_general_flags;
  logic             idleSel;
  logic             next_idleSel;
  logic             stopSel;
  logic             next_stopSel;
  logic             vbusSync;
  logic             extRstSync;
  logic             suspended;
  logic             next_suspended;
  logic [MCD_W-1:0] mcdCount;
  logic [MCD_W-1:0] next_mcdCount;
  logic [7:0]       next_rdata;
  cpm_gate_t        next_gate;
  logic             next_coreReset;
  logic             next_serviceInt;
  logic             next_intOscRun;

  // Both pins come from outside the clock domain
  cpm_sync uVbus (
    .mclk(mclk),
    .rst (rst),
    .din (vbusPin),
    .dout(vbusSync)
  );
  cpm_sync uRst (
    .mclk(mclk),
    .rst (rst),
    .din (extResetPin),
    .dout(extRstSync)
  );

  wire pcWrite   = hitsPowerControl(sfr.write, sfr.addr);
  wire pcRead    = hitsPowerControl(sfr.read, sfr.addr);
  wire inReset   = (state == CPM_RESET);
  wire inIdle    = (state == CPM_IDLE);
  wire inStop    = (state == CPM_STOP);
  wire nextIdle  = (next_state == CPM_IDLE);
  wire nextStop  = (next_state == CPM_STOP);
  wire wdtReset  = wdtEnable && wdtExpire && inIdle;
  // Oscillator is off in stop, so the detector sees no clock and fires
  wire mcdReset  = mcdEnable && inStop && (mcdCount >= MCD_LAST);
  wire anyReset  = extRstSync || wdtReset || mcdReset;
  wire vbusMatch = (vbusSync == vbus_wake_polarity);
  wire oscWake   = usbEvent || vbusMatch;
  wire idleWake  = inIdle && intPending;

  always_comb begin
    next_state = state;
    unique case (state)
      CPM_RUN: begin
        // Selection takes effect only at the instruction boundary
        if (anyReset) next_state = CPM_RESET;
        else if (instrDone && stopSel) next_state = CPM_STOP;
        else if (instrDone && idleSel) next_state = CPM_IDLE;
      end
      CPM_IDLE: begin
        if (anyReset) next_state = CPM_RESET;
        else if (intPending) next_state = CPM_RUN;
      end
      CPM_STOP: begin
        // Interrupts ignored here
        if (anyReset) next_state = CPM_RESET;
      end
      CPM_RESET: begin
        // Held here while the synchronised external reset stays asserted
        if (!anyReset) next_state = CPM_RUN;
      end
      default: next_state = CPM_RESET;
    endcase
  end

  // Clear on any reset so software reads the reset value again
  assign next_general_flags = inReset ? CPM_POWER_CONTROL_RST[7:CPM_FLAGS_LSB]
                            : pcWrite ? sfr.wdata[7:CPM_FLAGS_LSB]
                            : general_flags;
  // Interrupt clear beats a write in the same cycle
  assign next_idleSel = inReset  ? CPM_POWER_CONTROL_RST[CPM_IDLE_BIT]
                      : idleWake ? 1'b0
                      : pcWrite  ? sfr.wdata[CPM_IDLE_BIT]
                      : (nextIdle || nextStop) ? 1'b0
                      : idleSel;
  // Self-clear on entry, so a wake never re-enters the mode
  assign next_stopSel = inReset ? CPM_POWER_CONTROL_RST[CPM_STOP_BIT]
                      : pcWrite ? sfr.wdata[CPM_STOP_BIT]
                      : (nextIdle || nextStop) ? 1'b0
                      : stopSel;
  // Saturates so a long stop cannot wrap below the limit
  assign next_mcdCount = !inStop ? '0
                       : (mcdCount < MCD_FULL) ? mcdCount + MCD_STEP
                       : mcdCount;
  // Wake wins over a fresh request
  assign next_suspended = oscWake ? 1'b0
                        : suspendReq ? 1'b1
                        : suspended;

  assign next_rdata      = pcRead ? {general_flags, 2'b00} : rdata;
  // Clocks and peripherals keep running in idle; only the CPU stalls
  assign next_gate       = '{cpuHalt:    nextIdle || nextStop,
                             oscStop:    nextStop,
                             periphStop: nextStop,
                             intGate:    nextStop};
  assign next_coreReset  = (next_state == CPM_RESET);
  assign next_serviceInt = idleWake && !anyReset;
  assign next_intOscRun  = !nextStop && !(suspended && !oscWake);

  // Power-up lands in the reset state so the core sees coreReset
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= CPM_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      general_flags <= CPM_POWER_CONTROL_RST[7:CPM_FLAGS_LSB];
      idleSel       <= CPM_POWER_CONTROL_RST[CPM_IDLE_BIT];
      stopSel       <= CPM_POWER_CONTROL_RST[CPM_STOP_BIT];
    end else begin
      general_flags <= next_general_flags;
      idleSel       <= next_idleSel;
      stopSel       <= next_stopSel;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mcdCount <= '0;
    end else begin
      mcdCount <= next_mcdCount;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      suspended <= 1'b0;
    end else begin
      suspended <= next_suspended;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= CPM_POWER_CONTROL_RST;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Constant, but registered so every output leaves a flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      resetVector <= CPM_RESET_VECTOR;
    end else begin
      resetVector <= CPM_RESET_VECTOR;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gate      <= '0;
      coreReset <= 1'b1;
      mode      <= CPM_RESET;
    end else begin
      gate      <= next_gate;
      coreReset <= next_coreReset;
      mode      <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      serviceInt <= 1'b0;
      intOscRun  <= 1'b0;
    end else begin
      serviceInt <= next_serviceInt;
      intOscRun  <= next_intOscRun;
    end
  end
endmodule

/* File: cpm_pmc_checker.sv */
// Port checker for the power-mode controller.
// Assumes one clock domain and the synchronous active-high reset.
module cpm_pmc_checker
  import cpm_pkg::*;
#(
  parameter int MCD_CYCLES = CPM_MCD_CYCLES
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire cpm_sfr_t    sfr,
  input wire logic        instrDone,
  input wire logic        intPending,
  input wire logic        wdtEnable,
  input wire logic        wdtExpire,
  input wire logic        mcdEnable,
  input wire logic [7:0]  rdata,
  input wire cpm_gate_t   gate,
  input wire logic        coreReset,
  input wire logic [15:0] resetVector,
  input wire logic        serviceInt,
  input wire logic [1:0]  mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  int stopCnt;
  // Slack of three covers the reset pulse after the timeout
  always_ff @(posedge mclk) begin
    if (rst || mode != CPM_STOP || !mcdEnable) stopCnt <= 0;
    else stopCnt <= stopCnt + 1;
  end
  chk_idle_entry: assert property ((mode == CPM_IDLE && $past(mode) == CPM_RUN)
    |-> $past(instrDone)) else $error("idle entered off a boundary");
  chk_idle_clocks: assert property (mode == CPM_IDLE
    |-> gate.cpuHalt && !gate.oscStop && !gate.periphStop) else $error("idle gating wrong");
  chk_idle_wake: assert property ((mode == CPM_IDLE && intPending && !wdtExpire)
    |=> mode == CPM_RUN && serviceInt) else $error("interrupt did not wake");
  chk_stop_gates: assert property (mode == CPM_STOP |-> gate == 4'hf)
    else $error("stop gating wrong");
  chk_stop_noint: assert property (mode == CPM_STOP |=> !serviceInt)
    else $error("interrupt served in stop");
  chk_reset_vec: assert property (coreReset |-> resetVector == CPM_RESET_VECTOR)
    else $error("reset vector not zero");
  chk_flags_read: assert property ($past(sfr.read) |-> rdata[1:0] == 2'b00)
    else $error("mode bits read back");
  chk_wdt_idle: assert property ((mode == CPM_IDLE && wdtEnable && wdtExpire)
    |-> ##[0:3] coreReset) else $error("watchdog did not reset");
  chk_mcd_bound: assert property (stopCnt <= MCD_CYCLES + 3)
    else $error("missing clock reset late");
  chk_stop_exit: assert property (mode == CPM_STOP
    |=> mode == CPM_STOP || mode == CPM_RESET) else $error("stop left without reset");
  chk_reset_mode: assert property (coreReset |-> mode == CPM_RESET)
    else $error("core reset outside reset mode");
endmodule
bind cpm_power_mode_control cpm_pmc_checker #(.MCD_CYCLES(MCD_CYCLES)) chk_u (.mclk, .rst,
  .sfr, .instrDone, .intPending, .wdtEnable, .wdtExpire, .mcdEnable, .rdata, .gate,
  .coreReset, .resetVector, .serviceInt, .mode);

/* File: testbench.sv */
// Self-checking bench for the power-mode controller.
// Assumes the package and the controller are compiled first.
module testbench
  import cpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 0, rst = 1, instrDone = 0, intPending = 0, wdtEnable = 0;
  logic        wdtExpire = 0, mcdEnable = 0, extResetPin = 0, suspendReq = 0;
  logic        usbEvent = 0, vbusPin = 0, vbus_wake_polarity = 1;
  cpm_sfr_t    sfr = '0;
  logic [7:0]  rdata;
  cpm_gate_t   gate;
  logic        coreReset, serviceInt, intOscRun;
  logic [15:0] resetVector;
  logic [1:0]  mode;
  int          err_count = 0, total_checks = 0;
  always #4 mclk = ~mclk;
  // Small count keeps the stop timeout short
  cpm_power_mode_control #(.MCD_CYCLES(8)) dut_u (.mclk, .rst, .sfr, .instrDone,
    .intPending, .wdtEnable, .wdtExpire, .mcdEnable, .extResetPin, .suspendReq, .usbEvent,
    .vbusPin, .vbus_wake_polarity, .rdata, .gate, .coreReset, .resetVector, .serviceInt,
    .intOscRun, .mode);
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] d);
    sfr = '{1'b1, 1'b0, CPM_POWER_CONTROL_ADDR, d};
    tick();
    sfr = '0;
    tick();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    tick();
    sfr = '0;
    chk(rdata, exp);
    tick();
  endtask
  task automatic enter(logic [7:0] d, logic [1:0] m);
    wr(d);
    chk(mode, CPM_RUN);
    instrDone = 1;
    tick();
    instrDone = 0;
    chk(mode, m);
  endtask
  task automatic waitrst();
    for (int i = 0; i < 30 && coreReset !== 1'b1; i++) tick();
    chk(coreReset, 1);
    chk(resetVector, CPM_RESET_VECTOR);
    tick(6);
    chk(mode, CPM_RUN);
    rd(CPM_POWER_CONTROL_ADDR, 8'h00);
  endtask
  task automatic t_idle();
    wr(8'hfc);
    rd(8'h88, 8'h00);
    rd(CPM_POWER_CONTROL_ADDR, 8'hfc);
    enter(8'hfd, CPM_IDLE);
    tick(3);
    chk(gate, 4'h8);
    intPending = 1;
    tick();
    intPending = 0;
    chk(serviceInt, 1);
    chk(mode, CPM_RUN);
    rd(CPM_POWER_CONTROL_ADDR, 8'hfc);
  endtask
  task automatic t_resets();
    wdtEnable = 1;
    enter(8'h01, CPM_IDLE);
    wdtExpire = 1;
    tick();
    wdtExpire = 0;
    waitrst();
    enter(8'h02, CPM_STOP);
    chk(gate, 4'hf);
    chk(intOscRun, 0);
    intPending = 1;
    tick(4);
    chk(mode, CPM_STOP);
    chk(serviceInt, 0);
    intPending = 0;
    // Pin must hold long enough for two agreeing samples
    extResetPin = 1;
    tick(3);
    chk(mode, CPM_STOP);
    extResetPin = 0;
    waitrst();
    mcdEnable = 1;
    enter(8'h02, CPM_STOP);
    waitrst();
    mcdEnable = 0;
  endtask
  task automatic t_susp();
    suspendReq = 1;
    tick();
    suspendReq = 0;
    tick(4);
    chk(intOscRun, 0);
    vbusPin = 1;
    tick(6);
    chk(intOscRun, 1);
    vbus_wake_polarity = 0;
    suspendReq = 1;
    tick();
    suspendReq = 0;
    tick(2);
    chk(intOscRun, 0);
    usbEvent = 1;
    tick(2);
    chk(intOscRun, 1);
    usbEvent = 0;
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
  initial begin
    tick(8);
    rst = 0;
    tick(2);
    t_idle();
    t_resets();
    t_susp();
    end_sim();
  end
endmodule
